// ### hdl/metering_cfg_pkg.sv
// Constants, register map and carrier types for the metering config bank.
// Assumes a 40 MHz aclk and a 32-bit AXI4-Lite register bus.
package metering_cfg_pkg;
    // Printed offsets are not multiples of four: indices, byte address = 4x
    localparam logic [11:0] IDX_CSUM_FORCE = 12'h4B4;
    localparam logic [11:0] IDX_CSUM_OPT = 12'h4B5;
    localparam logic [11:0] IDX_TEMP_CTL = 12'h4B6;
    localparam logic [11:0] IDX_TEMP_RES = 12'h4B7;
    localparam logic [11:0] IDX_GAIN = 12'h4B9;
    localparam logic [11:0] IDX_CONV_DIS = 12'h4BA;
    localparam logic [11:0] IDX_REACT_DIS = 12'h4E0;
    localparam logic [11:0] IDX_IRQ_STAT = 12'h500;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h501;
    localparam logic [15:0] RST_REG = 16'h0000;
    // Field layout
    localparam int TEMP_START_BIT = 3;
    localparam int TEMP_EN_BIT = 2;
    localparam logic [15:0] OPT_MASK = 16'h0FFF;
    localparam logic [15:0] TEMP_CTL_MASK = 16'h0007;
    localparam logic [15:0] RES_MASK = 16'h0FFF;
    localparam logic [15:0] GAIN_MASK = 16'h3FFF;
    localparam logic [15:0] CONV_MASK = 16'h007F;
    localparam logic [15:0] REACT_MASK = 16'h0001;
    localparam logic [15:0] IRQ_MASK_BITS = 16'h0003;
    localparam int IRQ_TEMP_RDY = 0;
    localparam int IRQ_CSUM_DONE = 1;
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int CONV_TIME_US = 1000;
    localparam int CONV_CYCLES = CLK_HZ / 1_000_000 * CONV_TIME_US;
    localparam int CSUM_REGS = 12;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] volt_c_gain;
        logic [1:0] volt_b_gain;
        logic [1:0] volt_a_gain;
        logic [1:0] neutral_gain;
        logic [1:0] cur_c_gain;
        logic [1:0] cur_b_gain;
        logic [1:0] cur_a_gain;
    } gain_s;

    typedef struct packed {
        logic volt_c_conv_off;
        logic volt_b_conv_off;
        logic volt_a_conv_off;
        logic neutral_conv_off;
        logic cur_c_conv_off;
        logic cur_b_conv_off;
        logic cur_a_conv_off;
    } conv_off_s;

    typedef struct packed {
        logic sum_zero_cross_select;
        logic sum_zero_cross_timeout;
        logic sum_apparent_noload;
        logic sum_reactive_noload;
        logic sum_active_noload;
        logic sum_swell_cycles;
        logic sum_swell_level;
        logic sum_sag_cycles;
        logic sum_sag_level;
        logic sum_event_mask;
        logic sum_irq_mask_second;
        logic sum_irq_mask_first;
    } csum_sel_s;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_RUN = 2'b01
    } conv_state_e;
endpackage

// ### hdl/metering_config_regs.sv
// Configuration and status register bank of a multiphase metering device.
// Assumes an AXI4-Lite master on aclk; sensor and checksum engines outside.
// Summary of operation
// - Option bits 11..7 add zero-cross, timeout and three no-load registers.
// - Option bits 6..3 add swell cycles, swell level, sag cycles, sag level.
// - Option bits 2..0 add event mask, mask two, mask one; reset zero.
// - Writing one to start bit, with enable bit one in the same write, requests a conversion; bit self-clears.
// - Manual result arrives within 1 ms and sets the ready status flag.
// - Sensor enable bit turns the sensor on; resets off.
// - Averaging code picks 1/256/512/1024 samples; the result wait stays CONV_CYC cycles.
// - Result register shows 12-bit value; upper four bits read zero.
// - Gain codes: 00 gain 1, 01 gain 2, 10 and 11 gain 4.
// - Gain fields: volts C,B,A at 13..8, neutral 7:6, currents 5..0.
// - Disable bits 6..0 shut off converters VC,VB,VA,IN,IC,IB,IA.
// - Reactive disable bit stops total reactive power; resets active.
// - Force-update write starts checksum; completion sets done flag.
`timescale 1ns/10ps
module metering_config_regs
    import metering_cfg_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES,
    parameter int CSUM_CYC = CSUM_REGS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [11:0] sensor_sample,
    output logic sensor_enable,
    output logic [1:0] sensor_avg_sel,
    output logic [10:0] sensor_avg_count,
    output gain_s gain_sel,
    output logic [2:0] gain_factor [7],
    output conv_off_s conv_off,
    output logic reactive_calc_off,
    output csum_sel_s csum_sel,
    output logic csum_start,
    output logic irq
);
    import metering_cfg_pkg::*;

    default clocking dflt_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Counts below these cannot form a strobe, a wait and a done cycle
    if (CONV_CYC < 2 || CSUM_CYC < 1) begin : g_bad_counts
        $error("metering_config_regs: count parameters too small");
    end

    function automatic logic [2:0] gain_of(input logic [1:0] code);
        unique case (code)
            2'b00: gain_of = 3'h1;
            2'b01: gain_of = 3'h2;
            default: gain_of = 3'h4;
        endcase
    endfunction

    function automatic logic [15:0] apply_strb(input logic [15:0] old,
            input logic [31:0] wd, input logic [3:0] st,
            input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (st[0]) v[7:0] = wd[7:0];
        if (st[1]) v[15:8] = wd[15:8];
        apply_strb = v & mask;
    endfunction

    logic aw_held_q, w_held_q;
    logic [11:0] aw_idx_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic wr_hit;
    logic [15:0] opt_q, temp_ctl_q, result_q, gain_q, conv_q, react_q;
    logic [15:0] stat_q, mask_q;
    logic start_q;
    conv_state_e conv_state_q;
    logic [31:0] conv_cnt_q;
    logic csum_busy_q;
    logic [31:0] csum_cnt_q;
    logic temp_done, csum_done;

    // Write channel: address and data taken independently, in either order
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_idx_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[13:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case (aw_idx_q)
            IDX_CSUM_FORCE, IDX_CSUM_OPT, IDX_TEMP_CTL, IDX_TEMP_RES,
            IDX_GAIN, IDX_CONV_DIS, IDX_REACT_DIS, IDX_IRQ_STAT,
            IDX_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Configuration registers; reserved bits masked away
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opt_q <= RST_REG;
            temp_ctl_q <= RST_REG;
            gain_q <= RST_REG;
            conv_q <= RST_REG;
            react_q <= RST_REG;
            mask_q <= RST_REG;
        end else if (wr_fire) begin
            unique case (aw_idx_q)
                IDX_CSUM_OPT: opt_q <= apply_strb(opt_q, wdata_q, wstrb_q,
                    OPT_MASK);
                IDX_TEMP_CTL: temp_ctl_q <= apply_strb(temp_ctl_q, wdata_q,
                    wstrb_q, TEMP_CTL_MASK);
                IDX_GAIN: gain_q <= apply_strb(gain_q, wdata_q, wstrb_q,
                    GAIN_MASK);
                IDX_CONV_DIS: conv_q <= apply_strb(conv_q, wdata_q, wstrb_q,
                    CONV_MASK);
                IDX_REACT_DIS: react_q <= apply_strb(react_q, wdata_q,
                    wstrb_q, REACT_MASK);
                IDX_IRQ_MASK: mask_q <= apply_strb(mask_q, wdata_q, wstrb_q,
                    IRQ_MASK_BITS);
                default: ;
            endcase
        end
    end

    // Start request is a one-cycle strobe; TEMP_CTL_MASK drops bit 3, so the stored bit always reads 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= 1'b0;
        end else begin
            start_q <= wr_fire && aw_idx_q == IDX_TEMP_CTL && wstrb_q[0]
                && wdata_q[TEMP_START_BIT]
                && wdata_q[TEMP_EN_BIT];
        end
    end

    // Conversion timer; a new start restarts the 1 ms wait
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_state_q <= CONV_IDLE;
            conv_cnt_q <= 32'h0000_0000;
            result_q <= RST_REG;
        end else begin
            unique case (conv_state_q)
                CONV_IDLE: begin
                    if (start_q) begin
                        conv_state_q <= CONV_RUN;
                        conv_cnt_q <= 32'h0000_0000;
                    end
                end
                CONV_RUN: begin
                    if (!temp_ctl_q[TEMP_EN_BIT]) begin
                        conv_state_q <= CONV_IDLE;
                    end else if (start_q) begin
                        conv_cnt_q <= 32'h0000_0000;
                    end else if (conv_cnt_q == 32'(CONV_CYC - 1)) begin
                        conv_state_q <= CONV_IDLE;
                        result_q <= {4'h0, sensor_sample} & RES_MASK;
                    end else begin
                        conv_cnt_q <= conv_cnt_q + 32'h0000_0001;
                    end
                end
                default: conv_state_q <= CONV_IDLE;
            endcase
        end
    end

    assign temp_done = conv_state_q == CONV_RUN && temp_ctl_q[TEMP_EN_BIT]
        && !start_q && conv_cnt_q == 32'(CONV_CYC - 1);

    // Checksum engine stand-in: counts CSUM_CYC cycles whatever the selection, then flags done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            csum_busy_q <= 1'b0;
            csum_cnt_q <= 32'h0000_0000;
        end else if (csum_start) begin
            csum_busy_q <= 1'b1;
            csum_cnt_q <= 32'h0000_0000;
        end else if (csum_busy_q) begin
            if (csum_cnt_q == 32'(CSUM_CYC - 1)) begin
                csum_busy_q <= 1'b0;
            end else begin
                csum_cnt_q <= csum_cnt_q + 32'h0000_0001;
            end
        end
    end

    assign csum_start = wr_fire && aw_idx_q == IDX_CSUM_FORCE
        && wstrb_q[0] && wdata_q[0];
    assign csum_done = csum_busy_q && !csum_start
        && csum_cnt_q == 32'(CSUM_CYC - 1);

    // Sticky status; a set in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= RST_REG;
        end else begin
            for (int i = 0; i < 16; i++) begin
                if ((i == IRQ_TEMP_RDY && temp_done) ||
                    (i == IRQ_CSUM_DONE && csum_done)) begin
                    stat_q[i] <= 1'b1;
                end else if (wr_fire && aw_idx_q == IDX_IRQ_STAT &&
                    wstrb_q[i / 8] && wdata_q[i]) begin
                    stat_q[i] <= 1'b0;
                end
            end
        end
    end

    assign irq = |(stat_q & mask_q);

    // Read channel
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr[13:2])
                IDX_CSUM_FORCE: s_axi_rdata <= 32'h0000_0000;
                IDX_CSUM_OPT: s_axi_rdata <= {16'h0000, opt_q};
                IDX_TEMP_CTL: s_axi_rdata <= {16'h0000, temp_ctl_q};
                IDX_TEMP_RES: s_axi_rdata <= {16'h0000, result_q};
                IDX_GAIN: s_axi_rdata <= {16'h0000, gain_q};
                IDX_CONV_DIS: s_axi_rdata <= {16'h0000, conv_q};
                IDX_REACT_DIS: s_axi_rdata <= {16'h0000, react_q};
                IDX_IRQ_STAT: s_axi_rdata <= {16'h0000, stat_q};
                IDX_IRQ_MASK: s_axi_rdata <= {16'h0000, mask_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Outputs to the analog front end and datapath
    assign sensor_enable = temp_ctl_q[TEMP_EN_BIT];
    assign sensor_avg_sel = temp_ctl_q[1:0];
    always_comb begin
        unique case (temp_ctl_q[1:0])
            2'b00: sensor_avg_count = 11'h001;
            2'b01: sensor_avg_count = 11'h100;
            2'b10: sensor_avg_count = 11'h200;
            default: sensor_avg_count = 11'h400;
        endcase
    end
    assign gain_sel = gain_s'(gain_q[13:0]);
    always_comb begin
        for (int c = 0; c < 7; c++) begin
            gain_factor[c] = gain_of(gain_q[2*c +: 2]);
        end
    end
    assign conv_off = conv_off_s'(conv_q[6:0]);
    assign reactive_calc_off = react_q[0];
    assign csum_sel = csum_sel_s'(opt_q[11:0]);

    // A start is a strobe followed by a fresh count in the next cycle
    sequence s_conv_begun;
        conv_state_q == CONV_RUN && conv_cnt_q == 32'h0000_0000;
    endsequence

    sequence s_csum_begun;
        csum_busy_q && csum_cnt_q == 32'h0000_0000;
    endsequence

    a_start_conv: assert property (
        start_q |=> s_conv_begun)
        else $error("start did not begin conversion");
    a_start_pulse: assert property (
        start_q |=> !start_q)
        else $error("start strobe held too long");
    a_start_gated: assert property (
        start_q |-> temp_ctl_q[TEMP_EN_BIT])
        else $error("start accepted while disabled");
    a_conv_abort: assert property (
        conv_state_q == CONV_RUN && !temp_ctl_q[TEMP_EN_BIT]
        |=> conv_state_q == CONV_IDLE)
        else $error("disabled sensor kept converting");
    a_ready_set: assert property (
        temp_done |=> stat_q[IRQ_TEMP_RDY])
        else $error("ready flag not set");
    a_csum_start: assert property (
        csum_start |=> s_csum_begun)
        else $error("checksum did not start");
    a_csum_done: assert property (
        csum_done |=> stat_q[IRQ_CSUM_DONE] && !csum_busy_q)
        else $error("checksum done not flagged");
    a_res_upper: assert property (
        result_q[15:12] == 4'h0)
        else $error("result upper bits set");
    a_reserved_zero: assert property (
        gain_q[15:14] == 2'h0 && conv_q[15:7] == 9'h000
        && react_q[15:1] == 15'h0000)
        else $error("reserved bits stored");
    a_opt_reset: assert property (disable iff (1'b0)
        !aresetn |=> opt_q == 16'h0000 && react_q == 16'h0000
        && temp_ctl_q == 16'h0000)
        else $error("reset values wrong");
    a_gain_map: assert property (
        gain_q[1:0] == 2'b01 |-> gain_factor[0] == 3'h2)
        else $error("gain decode wrong");
endmodule // metering_config_regs

// ### test/test_metering_config_regs.sv
// Self-checking bench for the metering configuration register bank.
// Assumes the design package; drives AXI4-Lite itself at 40 MHz.
`timescale 1ns/10ps
module test_metering_config_regs;
    import metering_cfg_pkg::*;
    // Short counts keep the run brief; expectations scale from them
    localparam int CONV_T = 20;
    localparam int CSUM_T = 4;
    logic aclk, aresetn, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
    logic [13:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [3:0] ws;
    logic [1:0] bre, rre, asel;
    logic [11:0] smp;
    logic sen, roff, cst, irq;
    logic [10:0] acnt;
    gain_s gs;
    logic [2:0] gf [7];
    conv_off_s co;
    csum_sel_s cs;
    integer n_fail, n_tests, n_st, k, c;
    integer mdl [int];
    logic [11:0] regs [9];
    int rwi [6] = '{1, 2, 4, 5, 6, 8};

    metering_config_regs #(.CONV_CYC(CONV_T), .CSUM_CYC(CSUM_T))
        i_metering_config_regs (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(bre), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rre),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .sensor_sample(smp),
        .sensor_enable(sen), .sensor_avg_sel(asel),
        .sensor_avg_count(acnt), .gain_sel(gs), .gain_factor(gf),
        .conv_off(co), .reactive_calc_off(roff), .csum_sel(cs),
        .csum_start(cst), .irq(irq));

    always #12.5 aclk = ~aclk;

    // The start pulse lasts one cycle, so it is counted rather than polled
    always @(posedge aclk) if (aresetn && cst) n_st <= n_st + 1;

    function automatic logic [15:0] msk(input logic [11:0] i);
        case (i)
            IDX_CSUM_OPT: return OPT_MASK;
            IDX_TEMP_CTL: return 16'h0007;
            IDX_GAIN: return GAIN_MASK;
            IDX_CONV_DIS: return CONV_MASK;
            IDX_REACT_DIS: return REACT_MASK;
            IDX_IRQ_MASK: return IRQ_MASK_BITS;
            default: return 16'h0000;
        endcase
    endfunction

    function automatic bit mapd(input logic [11:0] i);
        for (int j = 0; j < 9; j++)
            if (regs[j] == i) return 1'b1;
        return 1'b0;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkr(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: resp %h expected %h", $time, got, exp);
        end
    endtask

    task automatic clr();
        for (int j = 0; j < 9; j++) mdl[regs[j]] = 0;
    endtask

    task automatic axw(input logic [11:0] i, input logic [15:0] d);
        bit a, w;
        awa <= {i, 2'b00};
        wd <= {16'h0000, d};
        ws <= 4'hF;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        a = 0;
        w = 0;
        do begin
            @(posedge aclk);
            if (awr && !a) begin
                a = 1;
                awv <= 1'b0;
            end
            if (wrd && !w) begin
                w = 1;
                wv <= 1'b0;
            end
        end while (!(a && w));
        // Ready stays high between transfers, so it never toggles in one step
        do @(posedge aclk); while (!bv);
        chkr(bre, mapd(i) ? RESP_OKAY : RESP_SLVERR);
        if (i == IDX_IRQ_STAT) mdl[i] = mdl[i] & ~d;
        else if (mapd(i) && i != IDX_TEMP_RES) mdl[i] = d & msk(i);
    endtask

    task automatic rchk(input logic [11:0] i);
        ara <= {i, 2'b00};
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        do @(posedge aclk); while (!rv);
        chkr(rre, mapd(i) ? RESP_OKAY : RESP_SLVERR);
        chk(rdat, mapd(i) ? mdl[i] : 0);
    endtask

    task automatic pins();
        logic [13:0] g;
        logic [1:0] a;
        logic [1:0] f;
        g = 14'(mdl[IDX_GAIN]);
        a = 2'(mdl[IDX_TEMP_CTL]);
        chk(cs, mdl[IDX_CSUM_OPT]);
        chk(gs, g);
        chk(co, mdl[IDX_CONV_DIS]);
        chk(roff, mdl[IDX_REACT_DIS]);
        chk(sen, mdl[IDX_TEMP_CTL] >> 2);
        chk(asel, a);
        chk(acnt, a == 0 ? 1 : 256 << (a - 1));
        for (int j = 0; j < 7; j++) begin
            f = g[2*j+:2];
            chk(gf[j], f == 0 ? 1 : f == 1 ? 2 : 4);
        end
        chk(irq, |(mdl[IDX_IRQ_STAT] & mdl[IDX_IRQ_MASK]));
    endtask

    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        aclk = 0;
        {aresetn, awv, wv, br, arv, rr} = '0;
        {awa, ara, wd, ws, smp} = '0;
        n_fail = 0;
        n_tests = 0;
        n_st = 0;
        regs = '{IDX_CSUM_FORCE, IDX_CSUM_OPT, IDX_TEMP_CTL, IDX_TEMP_RES,
                 IDX_GAIN, IDX_CONV_DIS, IDX_REACT_DIS, IDX_IRQ_STAT,
                 IDX_IRQ_MASK};
        clr();
        c = $urandom(36524);
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (k = 0; k < 9; k++) rchk(regs[k]);
        pins();
        $display("test reset done");
        // Start bit kept clear so random traffic never launches a reading
        repeat (8) begin
            for (k = 0; k < 6; k++) begin
                c = $urandom;
                axw(regs[rwi[k]], 16'(c) & ~16'h0008);
            end
            for (k = 0; k < 9; k++) rchk(regs[k]);
            pins();
        end
        for (c = 0; c < 4; c++) begin
            axw(IDX_TEMP_CTL, 16'(c));
            axw(IDX_GAIN, {2'b00, {7{2'(c)}}});
            pins();
        end
        axw(IDX_REACT_DIS, 16'h0001);
        pins();
        $display("test fields done");
        axw(12'h4B8, 16'hFFFF);
        rchk(12'h4B8);
        axw(IDX_TEMP_RES, 16'hFFFF);
        rchk(IDX_TEMP_RES);
        $display("test unmapped done");
        smp <= 12'($urandom);
        axw(IDX_TEMP_CTL, 16'h0008);
        repeat (CONV_T + 10) @(posedge aclk);
        rchk(IDX_IRQ_STAT);
        rchk(IDX_TEMP_RES);
        axw(IDX_TEMP_CTL, 16'h000C);
        rchk(IDX_TEMP_CTL);
        repeat (CONV_T) @(posedge aclk);
        mdl[IDX_IRQ_STAT] = 1;
        mdl[IDX_TEMP_RES] = smp;
        rchk(IDX_IRQ_STAT);
        rchk(IDX_TEMP_RES);
        axw(IDX_TEMP_CTL, 16'h0000);
        axw(IDX_IRQ_MASK, 16'h0002);
        pins();
        axw(IDX_IRQ_MASK, 16'h0001);
        pins();
        axw(IDX_IRQ_STAT, 16'h0001);
        rchk(IDX_IRQ_STAT);
        pins();
        // Disabling mid-conversion must drop the reading and the flag
        smp <= ~smp;
        axw(IDX_TEMP_CTL, 16'h000C);
        axw(IDX_TEMP_CTL, 16'h0000);
        repeat (CONV_T + 5) @(posedge aclk);
        rchk(IDX_IRQ_STAT);
        rchk(IDX_TEMP_RES);
        $display("test temperature done");
        k = n_st;
        axw(IDX_CSUM_FORCE, 16'h0001);
        repeat (CSUM_T + 3) @(posedge aclk);
        chk(n_st - k, 1);
        mdl[IDX_IRQ_STAT] = 2;
        rchk(IDX_IRQ_STAT);
        rchk(IDX_CSUM_FORCE);
        axw(IDX_CSUM_FORCE, 16'hFFFE);
        chk(n_st - k, 1);
        axw(IDX_IRQ_MASK, 16'h0002);
        pins();
        $display("test checksum done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        clr();
        for (k = 0; k < 9; k++) rchk(regs[k]);
        pins();
        $display("test second reset done");
        results();
    end

    // The sequence needs under a thousand cycles; this limit is far beyond
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        results();
    end
endmodule // test_metering_config_regs
